/* File: rtl/coded_port_defs.svh */
// Constants for the coded frame parallel port.
`ifndef CODED_PORT_DEFS_SVH
`define CODED_PORT_DEFS_SVH

`define FRAME_BYTES 8'h0a
`define PAGE_FRAMES 8'h32
`define FIFO_DEPTH 8
`define DATA_WIDTH 8
`define MODE_IDLE 2'h0
`define MODE_DECODE 2'h1
`define MODE_ENCODE 2'h3

`endif

/* File: rtl/coded_port_pkg.sv */
// Types shared by the coded frame parallel port.
package coded_port_pkg;
   typedef logic [7:0] code_byte_t;

   typedef enum logic [1:0] {
      op_idle = 2'b00,
      op_decode = 2'b01,
      op_encode = 2'b11
   } op_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } stream_word_t;

   typedef struct packed {
      logic [7:0] data_out;
      logic data_oe_n;
      logic ready_to_read_n;
      logic ready_to_write_n;
      logic end_of_transfer_n;
   } port_pins_out_t;
endpackage

/* File: rtl/coded_word_fifo.sv */
// Defines nothing: the word FIFO module sits beside the port logic in coded_frame_parallel_port.sv.

/* File: rtl/coded_frame_parallel_port.sv */
// Byte-wide host port moving coded speech frames to and from the codec core.
`timescale 1ns/1ns
`include "coded_port_defs.svh"
module coded_frame_parallel_port (
   input wire logic clock,
   input wire logic rst_b,
   input wire coded_port_pkg::op_mode_t operation_mode_control,
   input wire logic headers_enable,
   input wire logic host_select_n,
   input wire logic request_or_direction,
   input wire logic [7:0] parallel_data_in,
   output logic [7:0] parallel_data_out,
   output logic parallel_data_oe_n,
   output logic ready_to_read_n,
   output logic ready_to_write_n,
   output logic end_of_transfer_n,
   input wire coded_port_pkg::code_byte_t enc_data,
   input wire logic enc_valid,
   output logic enc_ready,
   output coded_port_pkg::stream_word_t dec_word,
   output logic dec_valid,
   input wire logic dec_ready,
   output coded_port_pkg::op_mode_t active_mode
);
   import coded_port_pkg::*;

   // ==========================================================
   // Header byte lookup.
   function automatic code_byte_t header_byte(input logic [7:0] idx);
      unique case (idx)
         8'h00: header_byte = 8'h64;
         8'h01: header_byte = 8'h6d;
         8'h02: header_byte = 8'h72;
         8'h03: header_byte = 8'h31;
         8'h04: header_byte = 8'h64;
         8'h05: header_byte = 8'h61;
         8'h06: header_byte = 8'h74;
         8'h07: header_byte = 8'h61;
         8'h08: header_byte = 8'hf4;
         default: header_byte = 8'h01;
      endcase
   endfunction

   // ==========================================================
   // Pin synchronisers: two flops before any logic looks at a pin.
   logic [1:0] sel_meta;
   logic [1:0] req_meta;
   logic [7:0] din_meta;
   logic [7:0] din_sync;
   logic sel_n_s;
   logic sel_n_d;
   logic req_s;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sel_meta <= 2'h3;
         req_meta <= 2'h0;
         din_meta <= 8'h00;
         din_sync <= 8'h00;
         sel_n_d <= 1'b1;
      end else begin
         sel_meta <= {sel_meta[0], host_select_n};
         req_meta <= {req_meta[0], request_or_direction};
         din_meta <= parallel_data_in;
         din_sync <= din_meta;
         sel_n_d <= sel_n_s;
      end
   end
   assign sel_n_s = sel_meta[1];
   assign req_s = req_meta[1];

   // Select edges seen in the clock domain.
   logic sel_fall;
   logic sel_rise;
   assign sel_fall = sel_n_d && !sel_n_s;
   assign sel_rise = !sel_n_d && sel_n_s;

   // ==========================================================
   // Mode latch: a new mode only takes hold at a page boundary, so a stop
   // request lets the current page run out.
   op_mode_t mode;
   op_mode_t next_mode;
   logic [3:0] byte_cnt;
   logic [5:0] frame_cnt;
   logic in_header;
   logic page_start;
   logic byte_done;
   logic page_end;

   // A page boundary is idle, or both counters at zero with the header flag back at its
   // reload value. Toggling headers_enable in mid-page could fake a boundary, so it must
   // stay steady while a page runs.
   assign page_start = (mode == op_idle)
      || ((frame_cnt == 6'h00) && (byte_cnt == 4'h0) && (in_header == headers_enable));
   assign page_end = byte_done && !in_header && (byte_cnt == 4'(`FRAME_BYTES - 1))
      && (frame_cnt == 6'(`PAGE_FRAMES - 1));
   assign active_mode = mode;

   // The mode about to take hold; the ready flags use it so they never lag the mode by a cycle.
   assign next_mode = (page_start && !byte_done) ? operation_mode_control : mode;

   // Mode register.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mode <= op_idle;
      end else begin
         mode <= next_mode;
      end
   end

   // ==========================================================
   // Byte and frame counters and header flag shared by both directions.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         byte_cnt <= 4'h0;
         frame_cnt <= 6'h00;
         in_header <= 1'b0;
      end else if (mode == op_idle) begin
         byte_cnt <= 4'h0;
         frame_cnt <= 6'h00;
         in_header <= headers_enable;
      end else if (byte_done) begin
         if (byte_cnt == 4'(`FRAME_BYTES - 1)) begin
            byte_cnt <= 4'h0;
            if (in_header) begin
               in_header <= 1'b0;
            end else if (frame_cnt == 6'(`PAGE_FRAMES - 1)) begin
               frame_cnt <= 6'h00;
               in_header <= headers_enable;
            end else begin
               frame_cnt <= frame_cnt + 6'h01;
            end
         end else begin
            byte_cnt <= byte_cnt + 4'h1;
         end
      end
   end

   // ==========================================================
   // Decode direction: host writes bytes under a DMA-style request.
   logic in_push;
   logic in_ready;
   stream_word_t in_word;
   logic dec_take;

   // A byte is captured at the select rise while the request is held.
   assign dec_take = (mode == op_decode) && sel_rise && req_s;
   assign in_push = dec_take && in_ready;
   assign in_word.data = din_sync;
   assign in_word.last = page_end;

   coded_word_fifo #(
      .WIDTH(`DATA_WIDTH + 1),
      .DEPTH(`FIFO_DEPTH)
   ) in_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(in_push),
      .in_ready(in_ready),
      .in_data(in_word),
      .out_valid(dec_valid),
      .out_ready(dec_ready),
      .out_data(dec_word)
   );

   // ==========================================================
   // Encode direction: core bytes queue here, headers come from the table.
   logic out_valid;
   logic out_pop;
   code_byte_t out_byte;
   logic enc_take;
   logic have_byte;

   coded_word_fifo #(
      .WIDTH(`DATA_WIDTH),
      .DEPTH(`FIFO_DEPTH)
   ) out_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(enc_valid),
      .in_ready(enc_ready),
      .in_data(enc_data),
      .out_valid(out_valid),
      .out_ready(out_pop),
      .out_data(out_byte)
   );

   assign have_byte = in_header || out_valid;
   // The byte counts as read only when select rises with the qualifier high.
   assign enc_take = (mode == op_encode) && sel_rise && req_s && have_byte;
   assign out_pop = enc_take && !in_header;
   assign byte_done = enc_take || in_push;

   // ==========================================================
   // Data pin drive, launched on select fall and dropped on select rise.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         parallel_data_out <= 8'h00;
         parallel_data_oe_n <= 1'b1;
      end else if (mode == op_encode && sel_fall && have_byte) begin
         parallel_data_out <= in_header ? header_byte({4'h0, byte_cnt}) : out_byte;
         parallel_data_oe_n <= 1'b0;
      end else if (sel_rise || sel_n_s || mode != op_encode) begin
         parallel_data_oe_n <= 1'b1;
      end
   end

   // ==========================================================
   // Ready flags and end-of-page pulse.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ready_to_read_n <= 1'b1;
         ready_to_write_n <= 1'b1;
         end_of_transfer_n <= 1'b1;
      end else begin
         // Room means one free slot; each flag goes high at the edge that takes a byte, the same edge the fill count moves on.
         ready_to_read_n <= !((next_mode == op_decode) && in_ready && !in_push);
         ready_to_write_n <= !((next_mode == op_encode) && have_byte && !enc_take);
         end_of_transfer_n <= !((mode == op_decode) && in_push && page_end);
      end
   end
endmodule

// ==========================================================
// Word FIFO built from flip-flops with valid/ready on both sides.
module coded_word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] fill;
   logic push;
   logic pop;

   // ==========================================================
   // Handshake terms; the fill count has one spare bit so full and empty never alias.
   assign in_ready = (fill != (AW + 1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr];

   // Storage write; no reset so the array maps to plain flops.
   always_ff @(posedge clock) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level; pointers wrap explicitly so a depth that is not a power of two still works.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            fill <= fill + 1'b1;
         end else if (pop && !push) begin
            fill <= fill - 1'b1;
         end
      end
   end
endmodule

/* File: tb/coded_port_asserts.sv */
// Pin-level checks for the coded frame parallel port.
`timescale 1ns/1ns
module coded_port_checker (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic host_select_n,
   input wire logic [7:0] parallel_data_out,
   input wire logic parallel_data_oe_n,
   input wire logic ready_to_read_n,
   input wire logic ready_to_write_n,
   input wire logic end_of_transfer_n,
   input wire coded_port_pkg::op_mode_t active_mode
);
   import coded_port_pkg::*;

   // ==========================================
   // Pin checks
   // Reset masks every check except the reset check itself.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_drive_needs_select:
      assert property (!parallel_data_oe_n |-> !$past(host_select_n, 3)) else $error("drive without select");
   a_release_on_rise:
      assert property ($rose(host_select_n) |-> ##[1:3] parallel_data_oe_n) else $error("data not released");
   a_drive_only_encode:
      assert property (!parallel_data_oe_n |-> active_mode == op_encode) else $error("drive outside encode");
   a_data_held:
      assert property (!parallel_data_oe_n [*2] |-> $stable(parallel_data_out)) else $error("data moved");
   a_write_flag_mode:
      assert property (!ready_to_write_n |-> active_mode == op_encode) else $error("write flag outside encode");
   a_read_flag_mode:
      assert property (!ready_to_read_n |-> active_mode == op_decode) else $error("read flag outside decode");
   a_eot_pulse:
      assert property (!end_of_transfer_n |-> active_mode == op_decode ##1 end_of_transfer_n) else $error("bad eot");
   a_mode_legal:
      assert property (active_mode != 2'h2) else $error("illegal mode");
   a_reset_quiet:
      assert property (disable iff (1'b0) !rst_b |=> parallel_data_oe_n && ready_to_read_n && ready_to_write_n
         && end_of_transfer_n && active_mode == op_idle) else $error("pins not reset");
endmodule

bind coded_frame_parallel_port coded_port_checker chk (.clock(clock), .rst_b(rst_b),
   .host_select_n(host_select_n), .parallel_data_out(parallel_data_out),
   .parallel_data_oe_n(parallel_data_oe_n), .ready_to_read_n(ready_to_read_n),
   .ready_to_write_n(ready_to_write_n), .end_of_transfer_n(end_of_transfer_n), .active_mode(active_mode));

/* File: tb/host_model.sv */
// Behavioural host that works the select, request and data pins.
`timescale 1ns/1ns
module host_model (
   input wire logic clock,
   input wire logic [7:0] parallel_data_out,
   input wire logic parallel_data_oe_n,
   output logic host_select_n,
   output logic request_or_direction,
   output logic [7:0] parallel_data_in
);
   logic [7:0] host_val = 8'h00;
   logic host_drives = 1'b0;
   initial begin
      host_select_n = 1'b1;
      request_or_direction = 1'b0;
   end
   // A released bus shows the inverse of the last value, so stale data never looks valid.
   always_comb parallel_data_in = !parallel_data_oe_n ? parallel_data_out : host_drives ? host_val : ~host_val;
   // One select pulse, low and high four clocks each so the synchronisers see both edges.
   task automatic access(input logic req, input logic drive, input logic [7:0] val, output logic [7:0] got);
      @(negedge clock);
      host_select_n = 1'b0;
      request_or_direction = req;
      host_val = val;
      host_drives = drive;
      repeat (4) @(negedge clock);
      got = parallel_data_in;
      host_select_n = 1'b1;
      repeat (4) @(negedge clock);
      host_drives = 1'b0;
      request_or_direction = 1'b0;
   endtask
endmodule

/* File: tb/coded_frame_parallel_port_test.sv */
// Self-checking bench for the coded frame parallel port.
`timescale 1ns/1ns
module coded_frame_parallel_port_test;
   import coded_port_pkg::*;
   logic clock, rst_b, headers_enable, enc_valid, dec_valid, enc_ready, stall;
   logic dec_ready = 1'b0;
   logic took = 1'b0;
   op_mode_t operation_mode_control, active_mode;
   logic host_select_n, request_or_direction, parallel_data_oe_n;
   logic ready_to_read_n, ready_to_write_n, end_of_transfer_n;
   logic [7:0] parallel_data_in, parallel_data_out, got, b;
   code_byte_t enc_data;
   stream_word_t dec_word;
   int miscompares = 0, tests_run = 0, eot_seen = 0, n_dec = 0;
   logic [7:0] dec_q[$], enc_q[$];
   logic [7:0] hdr[10] = '{8'h64, 8'h6d, 8'h72, 8'h31, 8'h64, 8'h61, 8'h74, 8'h61, 8'hf4, 8'h01};

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   coded_frame_parallel_port DUT (.clock(clock), .rst_b(rst_b), .operation_mode_control(operation_mode_control),
      .headers_enable(headers_enable), .host_select_n(host_select_n), .request_or_direction(request_or_direction),
      .parallel_data_in(parallel_data_in), .parallel_data_out(parallel_data_out),
      .parallel_data_oe_n(parallel_data_oe_n), .ready_to_read_n(ready_to_read_n),
      .ready_to_write_n(ready_to_write_n), .end_of_transfer_n(end_of_transfer_n), .enc_data(enc_data),
      .enc_valid(enc_valid), .enc_ready(enc_ready), .dec_word(dec_word), .dec_valid(dec_valid),
      .dec_ready(dec_ready), .active_mode(active_mode));

   host_model host (.clock(clock), .parallel_data_out(parallel_data_out), .parallel_data_oe_n(parallel_data_oe_n),
      .host_select_n(host_select_n), .request_or_direction(request_or_direction),
      .parallel_data_in(parallel_data_in));

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic tally_and_finish;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Bounded wait for a ready flag; a hang ends the run as a failure.
   task automatic wait_until(input logic write_side);
      int k;
      k = 0;
      while ((write_side ? ready_to_write_n : ready_to_read_n) !== 1'b0 && k < 300) begin
         @(negedge clock);
         k++;
      end
      check(k < 300, "ready flag timeout");
      if (k >= 300) tally_and_finish();
   endtask

   // Core side: random stalls, and the reference order of bytes and page ends.
   always @(negedge clock) begin
      dec_ready <= !stall && ($urandom % 3 != 0);
      if (took) enc_data <= 8'($urandom);
   end
   always @(posedge clock) begin
      took <= enc_valid && enc_ready;
      if (enc_valid === 1'b1 && enc_ready === 1'b1) enc_q.push_back(enc_data);
      if (rst_b && end_of_transfer_n === 1'b0) eot_seen++;
      if (rst_b && dec_valid === 1'b1 && dec_ready === 1'b1) begin
         n_dec++;
         check(dec_q.size() > 0 && dec_word.data === dec_q.pop_front(), "decode byte");
         check(dec_word.last === (n_dec % 510 == 0), "page end flag");
      end
   end

   initial begin
      void'($urandom(40603));
      rst_b = 1'b0;
      stall = 1'b1;
      operation_mode_control = op_idle;
      headers_enable = 1'b1;
      enc_valid = 1'b0;
      enc_data = 8'h00;
      repeat (2) @(negedge clock);
      check(parallel_data_oe_n === 1'b1 && ready_to_read_n === 1'b1, "reset pins");
      rst_b = 1'b1;
      operation_mode_control = op_decode;
      // Decode a full page: fill the buffer first, then a refused pulse, then a stop before the end.
      for (int i = 0; i < 510; i++) begin
         if (i == 8) begin
            repeat (3) @(negedge clock);
            check(ready_to_read_n === 1'b1, "full buffer still ready");
            stall = 1'b0;
            wait_until(1'b0);
            host.access(1'b0, 1'b1, 8'h5a, got);
         end
         if (i == 505) operation_mode_control = op_idle;
         b = i < 10 ? hdr[i] : 8'($urandom);
         wait_until(1'b0);
         dec_q.push_back(b);
         host.access(1'b1, 1'b1, b, got);
      end
      repeat (40) @(negedge clock);
      check(n_dec == 510 && eot_seen == 1, "page count");
      check(active_mode === op_idle, "stop at page end");
      // Encode: a read without request is not consumed, then header and data follow.
      enc_valid = 1'b1;
      operation_mode_control = op_encode;
      wait_until(1'b1);
      check(active_mode === op_encode, "encode mode");
      host.access(1'b0, 1'b0, hdr[0], got);
      for (int i = 0; i < 14; i++) begin
         wait_until(1'b1);
         b = i < 10 ? hdr[i] : enc_q.pop_front();
         host.access(1'b1, 1'b0, b, got);
         check(got === b, "encode byte");
      end
      tally_and_finish();
   end
endmodule
